// >>> verilog/gpp_port.sv
// Function
// R01 - latch register; output pin with direction bit 0 drives latch bit
// R02 - direction register, bit n sets pin n input or output
// R03 - direction one tristates pin; zero puts latch on pin
// R04 - pin register reads pin levels, writes latch; latch reads stored value
// R05 - writing zero to pin or latch register clears all latch bits
// R06 - parallel slave enable, control bit 4, hands all pins to slave bus
// R07 - slave mode drives pins as outputs whatever the direction bits; here only while psp_drive is high
// R08 - slave mode also takes pins as data inputs, ignoring direction
// R09 - dual or quad pwm output disables parallel slave functions
// R10 - pins 0-3 analog at reset, inputs; analog pins read zero
// R11 - pin 4 compare or pwm a out at dir 0, capture in at 1
// R12 - pins 5-7 carry pwm b, c, d only when direction bit is 0
// R13 - unimplemented control bit reads zero, writes ignored
// R14 - port and registers exist only when variant has them
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned N_PINS       = GPP_PINS,
  parameter bit          PORT_PRESENT = 1'b1
) (
  input  wire logic [GPP_ADDR_W-1:0] addr,
  input  wire logic                  ccp_compare_en,
  input  wire logic [3:0]            ccp_out,
  input  wire logic [3:0]            ccp_own,
  input  wire logic                  ce,
  input  wire logic                  clk,
  input  wire logic [N_PINS-1:0]     pin_in,
  input  wire logic                  nrst,
  input  wire logic                  psp_drive,
  input  wire logic [N_PINS-1:0]     psp_data_out,
  input  wire logic                  psp_ibf,
  input  wire logic                  psp_obf,
  input  wire logic                  psp_overflow,
  input  wire logic                  rd,
  input  wire logic [GPP_DATA_W-1:0] wdata,
  input  wire logic                  wr,
  output logic                       capture_in,
  output logic [N_PINS-1:0]          pin_oe,
  output logic [N_PINS-1:0]          pin_out,
  output logic                       psp_active,
  output logic [N_PINS-1:0]          psp_data_in,
  output logic [GPP_DATA_W-1:0]      rdata
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (N_PINS != GPP_PINS) begin : g_bad_width
    $error("gpp_port serves exactly eight pins");
  end

  logic [7:0] latch;
  logic [7:0] direction;
  logic [7:0] psp_ctrl;
  logic [7:0] pwm_ctrl;
  logic [3:0] analog;
  logic [7:0] next_latch;
  logic [7:0] next_direction;
  logic [7:0] next_psp_ctrl;
  logic [7:0] next_pwm_ctrl;
  logic [3:0] next_analog;
  logic [7:0] next_rdata;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] pin_level;
  logic [7:0] pin_read;
  logic       pwm_multi;
  logic       psp_on;
  logic       wr_ok;
  logic       rd_ok;

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  gpp_sync #(
    .W (N_PINS)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .d    (pin_in),
    .q    (pin_level)
  );

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_ok     = wr & PORT_PRESENT; // see R14
    rd_ok     = rd & PORT_PRESENT; // see R14
    pwm_multi = pwm_ctrl[GPP_PWM_CFG_HI] | pwm_ctrl[GPP_PWM_CFG_LO];
    psp_on    = psp_ctrl[GPP_PSP_MODE_BIT] & ~pwm_multi; // see R06 see R09
    pin_read  = pin_level & ~{4'h0, analog}; // see R10
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb begin
    next_latch     = latch;
    next_direction = direction;
    next_psp_ctrl  = psp_ctrl;
    next_pwm_ctrl  = pwm_ctrl;
    next_analog    = analog;
    if (wr_ok) begin
      unique case (addr)
        GPP_OFS_PIN_LEVELS: next_latch = wdata; // see R04 see R05
        GPP_OFS_LATCH:      next_latch = wdata; // see R01 see R05
        GPP_OFS_DIRECTION:  next_direction = wdata; // see R02
        GPP_OFS_PSP_CTRL: begin
          next_psp_ctrl = wdata & GPP_PSP_RW_MASK; // see R13
        end
        GPP_OFS_PWM_CTRL:   next_pwm_ctrl = wdata;
        GPP_OFS_ANALOG:     next_analog = wdata[3:0];
        default: begin
        end
      endcase
    end
    next_psp_ctrl[GPP_PSP_IBF_BIT] = psp_ibf;
    next_psp_ctrl[GPP_PSP_OBF_BIT] = psp_obf;
    // overflow set beats software clear
    if (psp_overflow && psp_on) begin
      next_psp_ctrl[GPP_PSP_INPUT_BUFFER_OVERFLOW_BIT] = 1'b1;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd_ok) begin
      unique case (addr)
        GPP_OFS_PIN_LEVELS: next_rdata = pin_read; // see R04 see R10
        GPP_OFS_LATCH:      next_rdata = latch; // see R04
        GPP_OFS_DIRECTION:  next_rdata = direction;
        GPP_OFS_PSP_CTRL:   next_rdata = psp_ctrl; // see R13
        GPP_OFS_PWM_CTRL:   next_rdata = pwm_ctrl;
        GPP_OFS_ANALOG:     next_rdata = {4'h0, analog};
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch     <= GPP_RST_LATCH;
      direction <= GPP_RST_DIRECTION; // see R10
      psp_ctrl  <= GPP_RST_PSP_CTRL;
      pwm_ctrl  <= GPP_RST_PWM_CTRL;
      analog    <= GPP_RST_ANALOG; // see R10
      rdata     <= 8'h00;
    end else if (ce) begin
      latch     <= next_latch;
      direction <= next_direction;
      psp_ctrl  <= next_psp_ctrl;
      pwm_ctrl  <= next_pwm_ctrl;
      analog    <= next_analog;
      rdata     <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // per-pin output mux
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_pin
    logic alt_own;
    logic alt_val;
    if (i >= GPP_CCP_FIRST_PIN) begin : g_ccp
      // pin 4 also carries the compare output
      assign alt_own = ccp_own[i-4] | ((i == 4) && ccp_compare_en);
      assign alt_val = ccp_out[i-4]; // see R12
    end else begin : g_gpio
      assign alt_own = 1'b0;
      assign alt_val = 1'b0;
    end
    always_comb begin
      if (!PORT_PRESENT) begin
        next_pin_oe[i]  = 1'b0; // see R14
        next_pin_out[i] = 1'b0;
      end else if (psp_on) begin
        next_pin_oe[i]  = psp_drive; // see R07
        next_pin_out[i] = psp_data_out[i]; // see R07
      end else if (direction[i]) begin
        next_pin_oe[i]  = 1'b0; // see R03
        next_pin_out[i] = 1'b0;
      end else begin
        next_pin_oe[i]  = 1'b1; // see R03
        next_pin_out[i] = alt_own ? alt_val : latch[i]; // see R01 see R11
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_oe      <= 8'h00;
      pin_out     <= 8'h00;
      psp_active  <= 1'b0;
      psp_data_in <= 8'h00;
      capture_in  <= 1'b0;
    end else if (ce) begin
      pin_oe      <= next_pin_oe;
      pin_out     <= next_pin_out;
      psp_active  <= psp_on;
      psp_data_in <= psp_on ? pin_level : 8'h00; // see R08
      capture_in  <= direction[4] & pin_level[4]; // see R11
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_read(logic [2:0] a);
    ce && rd && addr == a;
  endsequence

  property p_latch_write;
    ce && wr && PORT_PRESENT &&
      (addr == GPP_OFS_LATCH || addr == GPP_OFS_PIN_LEVELS)
      |=> latch == $past(wdata);
  endproperty
  a_latch_write: assert property (p_latch_write) // see R05
    else $error("latch did not take written value");

  property p_dir_write;
    ce && wr && PORT_PRESENT && addr == GPP_OFS_DIRECTION
      |=> direction == $past(wdata);
  endproperty
  a_dir_write: assert property (p_dir_write) // see R02
    else $error("direction register did not update");

  property p_tristate;
    ce && !psp_on && direction[0] |=> !pin_oe[0];
  endproperty
  a_tristate: assert property (p_tristate) // see R03
    else $error("input pin driven");

  property p_gpio_drive;
    ce && PORT_PRESENT && !psp_on && !direction[1]
      |=> pin_oe[1] && pin_out[1] == $past(latch[1]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) // see R01
    else $error("output pin not showing latch");

  property p_psp_drive;
    ce && PORT_PRESENT && psp_on && psp_drive
      |=> pin_oe == 8'hff && pin_out == $past(psp_data_out);
  endproperty
  a_psp_drive: assert property (p_psp_drive) // see R07
    else $error("slave bus not driving pins");

  property p_pwm_blocks_psp;
    ce && pwm_multi && direction[5] |=> !pin_oe[5] && !psp_active;
  endproperty
  a_pwm_blocks_psp: assert property (p_pwm_blocks_psp) // see R09
    else $error("slave mode active under multi pwm");

  property p_analog_zero;
    s_read(GPP_OFS_PIN_LEVELS) ##0 analog[0] |=> rdata[0] == 1'b0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) // see R10
    else $error("analog pin read nonzero");

  property p_pwm_pin;
    ce && PORT_PRESENT && !psp_on && !direction[6] && ccp_own[2]
      |=> pin_out[6] == $past(ccp_out[2]) && pin_oe[6];
  endproperty
  a_pwm_pin: assert property (p_pwm_pin) // see R12
    else $error("pwm channel not on pin");

  property p_unimp_zero;
    s_read(GPP_OFS_PSP_CTRL) |=> rdata[GPP_PSP_UNIMP_BIT] == 1'b0;
  endproperty
  a_unimp_zero: assert property (p_unimp_zero) // see R13
    else $error("unimplemented bit read as one");

  property p_latch_read;
    s_read(GPP_OFS_LATCH) ##0 PORT_PRESENT |=> rdata == $past(latch);
  endproperty
  a_latch_read: assert property (p_latch_read) // see R04
    else $error("latch read mismatch");

  property p_psp_input;
    ce && psp_on |=> psp_data_in == $past(pin_level);
  endproperty
  a_psp_input: assert property (p_psp_input) // see R08
    else $error("slave bus input not taken from pins");

  property p_capture;
    ce && direction[4] |=> capture_in == $past(pin_level[4]);
  endproperty
  a_capture: assert property (p_capture) // see R11
    else $error("capture input not following pin");

  property p_psp_enable;
    ce && psp_ctrl[GPP_PSP_MODE_BIT] && !pwm_multi |=> psp_active;
  endproperty
  a_psp_enable: assert property (p_psp_enable) // see R06
    else $error("slave mode not active");

  property p_ce_freeze;
    !ce |=> $stable(latch) && $stable(direction) && $stable(pin_oe)
      && $stable(rdata);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) // see R01
    else $error("state changed while clock enable low");
endmodule // gpp_port

// >>> verilog/gpp_pkg.sv
package gpp_pkg;
  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned GPP_ADDR_W = 3;
  localparam int unsigned GPP_DATA_W = 8;
  localparam int unsigned GPP_PINS   = 8;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] GPP_OFS_PIN_LEVELS = 3'h0;
  localparam logic [2:0] GPP_OFS_LATCH      = 3'h1;
  localparam logic [2:0] GPP_OFS_DIRECTION  = 3'h2;
  localparam logic [2:0] GPP_OFS_PSP_CTRL   = 3'h3;
  localparam logic [2:0] GPP_OFS_PWM_CTRL   = 3'h4;
  localparam logic [2:0] GPP_OFS_ANALOG     = 3'h5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] GPP_RST_LATCH     = 8'h00;
  localparam logic [7:0] GPP_RST_DIRECTION = 8'hff;
  localparam logic [7:0] GPP_RST_PSP_CTRL  = 8'h07;
  localparam logic [7:0] GPP_RST_PWM_CTRL  = 8'h00;
  localparam logic [3:0] GPP_RST_ANALOG    = 4'hf;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned GPP_PSP_IBF_BIT   = 7;
  localparam int unsigned GPP_PSP_OBF_BIT   = 6;
  localparam int unsigned GPP_PSP_INPUT_BUFFER_OVERFLOW_BIT  = 5;
  localparam int unsigned GPP_PSP_MODE_BIT  = 4;
  localparam int unsigned GPP_PSP_UNIMP_BIT = 3;
  localparam int unsigned GPP_PWM_CFG_HI    = 7;
  localparam int unsigned GPP_PWM_CFG_LO    = 6;
  localparam int unsigned GPP_ANALOG_PINS   = 4;
  localparam int unsigned GPP_CCP_FIRST_PIN = 4;
  localparam logic [7:0]  GPP_PSP_RW_MASK   = 8'h37;
endpackage

// >>> verilog/gpp_sync.sv
`timescale 1ns/1ps
module gpp_sync
  import gpp_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  if (W < 1) begin : g_bad_w
    $error("gpp_sync needs at least one bit");
  end

  // ---------------------------------------------------------------
  // accept a level once stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    next_q = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & q);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule // gpp_sync

// >>> tb/gpp_pads.sv
`timescale 1ns/1ps
module gpp_pads
  import gpp_pkg::*;
(
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  output logic      [7:0] pin_in
);
  // ------------
  // wire levels
  // ------------
  // device wins a clash; an undriven wire floats up to the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule // gpp_pads

// >>> tb/gpp_port_test.sv
`timescale 1ns/1ps
module gpp_port_test;
  import gpp_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       ce = 1'b1;
  logic       cmp_en = 1'b0;
  logic [3:0] ccp_out = 4'h0;
  logic [3:0] ccp_own = 4'h0;
  logic       psp_drive = 1'b0;
  logic [7:0] psp_dout = 8'h00;
  logic       input_buffer_full = 1'b0;
  logic       output_buffer_full = 1'b0;
  logic       ovf = 1'b0;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_oe = 8'hff;
  logic [7:0] pin_in;
  logic [7:0] pin_oe;
  logic [7:0] pin_out;
  logic [7:0] psp_din;
  logic [7:0] rdata;
  logic       cap_in;
  logic       psp_active;
  logic [7:0] abs_oe;
  logic [7:0] abs_rdata;
  int         miscompares = 0;
  int         comparisons = 0;

  always #50 clk = ~clk;

  gpp_port dut_u (
    .addr(addr), .ccp_compare_en(cmp_en), .ccp_out(ccp_out),
    .ccp_own(ccp_own), .ce(ce), .clk(clk), .pin_in(pin_in),
    .nrst(nrst), .psp_drive(psp_drive), .psp_data_out(psp_dout),
    .psp_ibf(input_buffer_full), .psp_obf(output_buffer_full), .psp_overflow(ovf), .rd(rd),
    .wdata(wdata), .wr(wr), .capture_in(cap_in), .pin_oe(pin_oe),
    .pin_out(pin_out), .psp_active(psp_active),
    .psp_data_in(psp_din), .rdata(rdata)
  );

  gpp_port #(
    .PORT_PRESENT (1'b0)
  ) absent_u (
    .addr(addr), .ccp_compare_en(cmp_en), .ccp_out(ccp_out),
    .ccp_own(ccp_own), .ce(ce), .clk(clk), .pin_in(pin_in),
    .nrst(nrst), .psp_drive(psp_drive), .psp_data_out(psp_dout),
    .psp_ibf(input_buffer_full), .psp_obf(output_buffer_full), .psp_overflow(ovf), .rd(rd),
    .wdata(wdata), .wr(wr), .capture_in(), .pin_oe(abs_oe),
    .pin_out(), .psp_active(), .psp_data_in(), .rdata(abs_rdata)
  );

  gpp_pads pads_u (
    .pin_oe(pin_oe), .pin_out(pin_out), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_in(pin_in)
  );

  // ------------
  // bus tasks
  // ------------
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", w, e, g);
      miscompares++;
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, input logic [7:0] e,
                      input string w);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(w, e, rdata);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ------------
  // scenarios
  // ------------
  task automatic t_reset;
    chk("pin_oe", 8'h00, pin_oe);
    rreg(3'h1, 8'h00, "latch");
    rreg(3'h2, 8'hff, "direction");
    chk("absent rdata", 8'h00, abs_rdata);
    rreg(3'h3, 8'h07, "control");
    rreg(3'h4, 8'h00, "pwm");
    rreg(3'h6, 8'h00, "unmapped");
  endtask

  task automatic t_pins;
    ext_val <= 8'h5a;
    settle(6);
    rreg(3'h0, 8'h50, "analog pins");
    wreg(3'h5, 8'h00);
    settle(2);
    rreg(3'h0, 8'h5a, "pin levels");
  endtask

  task automatic t_latch;
    wreg(3'h1, 8'ha5);
    rreg(3'h1, 8'ha5, "latch");
    wreg(3'h2, 8'h00);
    settle(2);
    chk("pin_oe", 8'hff, pin_oe);
    chk("absent oe", 8'h00, abs_oe);
    chk("pin_out", 8'ha5, pin_out);
    wreg(3'h0, 8'h00);
    settle(2);
    chk("pin_out", 8'h00, pin_out);
    wreg(3'h1, 8'h3c);
    wreg(3'h1, 8'h00);
    rreg(3'h1, 8'h00, "latch");
    wreg(3'h2, 8'h0f);
    settle(2);
    chk("pin_oe", 8'hf0, pin_oe);
  endtask

  task automatic t_ccp;
    ccp_own <= 4'hf;
    ccp_out <= 4'ha;
    settle(2);
    chk("pwm out", 8'ha0, pin_out);
    ccp_own <= 4'h0;
    cmp_en <= 1'b1;
    ccp_out <= 4'h1;
    settle(2);
    chk("compare out", 8'h10, pin_out);
    wreg(3'h2, 8'hff);
    settle(6);
    chk("pin_oe", 8'h00, pin_oe);
    chk("capture", 8'h01, {7'h00, cap_in});
    ext_val <= 8'h4a;
    settle(6);
    chk("capture", 8'h00, {7'h00, cap_in});
    cmp_en <= 1'b0;
  endtask

  task automatic t_psp;
    wreg(3'h3, 8'h10);
    psp_drive <= 1'b1;
    psp_dout <= 8'hc3;
    settle(2);
    chk("active", 8'h01, {7'h00, psp_active});
    chk("pin_oe", 8'hff, pin_oe);
    chk("pin_out", 8'hc3, pin_out);
    psp_drive <= 1'b0;
    ext_val <= 8'h96;
    settle(6);
    chk("slave in", 8'h96, psp_din);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    rreg(3'h3, 8'h30, "control");
    for (int m = 1; m < 4; m++) begin
      wreg(3'h4, 8'(m << 6));
      settle(2);
      chk("active", 8'h00, {7'h00, psp_active});
      wreg(3'h4, 8'h00);
      settle(2);
      chk("active", 8'h01, {7'h00, psp_active});
    end
    wreg(3'h4, 8'h00);
    wreg(3'h3, 8'h00);
    rreg(3'h3, 8'h00, "control");
  endtask

  task automatic t_ctrl;
    input_buffer_full <= 1'b1;
    output_buffer_full <= 1'b1;
    wreg(3'h3, 8'hff);
    rreg(3'h3, 8'hf7, "control");
    input_buffer_full <= 1'b0;
    output_buffer_full <= 1'b0;
    wreg(3'h3, 8'h07);
    rreg(3'h3, 8'h07, "control");
  endtask

  task automatic t_ce;
    ce <= 1'b0;
    wreg(3'h1, 8'h5a);
    ce <= 1'b1;
    rreg(3'h1, 8'h00, "frozen latch");
  endtask

  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    settle(1);
    t_reset();
    t_pins();
    t_latch();
    t_ccp();
    t_psp();
    t_ctrl();
    t_ce();
    results();
  end
endmodule // gpp_port_test
